// ---- pkg/lane_ctrl_pkg.sv ----
package lane_ctrl_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_TEST   = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;

  // Control and test register fields
  localparam int FMT_LSB    = 0;
  localparam int FMT_W      = 4;
  localparam int GRP_BIT    = 4;
  localparam int LINK_BIT   = 5;
  localparam int CHEN_LSB   = 6;
  localparam int TEST_LSB   = 0;
  localparam int TEST_W     = 4;

  // Status register fields
  localparam int ST_SHDN_BIT = 0;
  localparam int ST_RAMP_BIT = 1;
  localparam int ST_RED_BIT  = 2;
  localparam int ST_LANE_LSB = 8;

  // Reset values
  localparam logic [3:0] RST_FMT  = 4'hE;
  localparam logic [1:0] RST_CHEN = 2'h3;
  localparam logic [3:0] RST_TEST = 4'h0;

  // Link formats that have a lane map here
  localparam logic [3:0] FMT_0  = 4'h0;
  localparam logic [3:0] FMT_14 = 4'hE;
  localparam logic [3:0] FMT_15 = 4'hF;

  // Serializer test selector codes
  localparam logic [3:0] TST_OFF    = 4'h0;
  localparam logic [3:0] TST_PRBS7  = 4'h1;
  localparam logic [3:0] TST_PRBS9  = 4'h2;
  localparam logic [3:0] TST_PRBS15 = 4'h3;
  localparam logic [3:0] TST_PRBS23 = 4'h4;
  localparam logic [3:0] TST_PRBS31 = 4'h5;
  localparam logic [3:0] TST_CLOCK  = 4'h6;
  localparam logic [3:0] TST_RAMP   = 4'h7;
  localparam logic [3:0] TST_SHORT  = 4'h8;

  // Fixed patterns
  localparam logic [47:0] CLK_PAT48 = 48'hFF00_FF00_FF00;
  localparam logic [3:0]  SHORT_TAIL = 4'h0;
  localparam logic [7:0]  RAMP_STEP = 8'h03;

  // Lane word geometry
  localparam int LANES   = 8;
  localparam int SAMP_W  = 12;
  localparam int LANE_W  = 24;
  localparam int SPC     = 8;
  localparam int NCH     = 4;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ---- rtl/serdes_test_pattern_lane_control.sv ----
`timescale 1ns/10ps
// What this block does
// - Sync header uses CRC-12 only, never CRC-3
// - Redundant lanes only in formats with four lanes
// - Lanes 0-3 default group, 4-7 alternate group
// - Group select picks lanes in four-lane formats; only that group drives
// - Shutdown input high disables every serial driver
// - Registers survive shutdown unchanged
// - Pair enable never powers down all four channels
// - Lane count follows link format in test modes
// - PRBS bypasses transport and link layers
// - PRBS7, PRBS9, PRBS15 taps as specified
// - PRBS23, PRBS31 taps as specified
// - Each lane starts PRBS at a distinct phase
// - Clock pattern repeats eight ones, eight zeros
// - Ramp keeps link layer, ignores formatter input
// - Ramp starts after alignment or serializer init
// - Ramp octets count 00 to FF on all lanes
// - Short transport pattern repeats fixed per-format layout
// - Format 0 pattern: five values per lane, tail
// - Format 14: channel per lane pair, even/odd
// - Format 15: A over lanes 0-3, B 4-7
module serdes_test_pattern_lane_control (
  // Clock and reset
  input  wire logic                     clk,
  input  wire logic                     rst_b,
  // AXI4-Lite write address and data
  input  wire logic [7:0]               s_axi_awaddr,
  input  wire logic                     s_axi_awvalid,
  output logic                          s_axi_awready,
  input  wire logic [31:0]              s_axi_wdata,
  input  wire logic [3:0]               s_axi_wstrb,
  input  wire logic                     s_axi_wvalid,
  output logic                          s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]                    s_axi_bresp,
  output logic                          s_axi_bvalid,
  input  wire logic                     s_axi_bready,
  // AXI4-Lite read
  input  wire logic [7:0]               s_axi_araddr,
  input  wire logic                     s_axi_arvalid,
  output logic                          s_axi_arready,
  output logic [31:0]                   s_axi_rdata,
  output logic [1:0]                    s_axi_rresp,
  output logic                          s_axi_rvalid,
  input  wire logic                     s_axi_rready,
  // Device pins and link status
  input  wire logic                     full_shutdown_input,
  input  wire logic                     serdes_ready,
  input  wire logic                     align_seq_done,
  // Converter samples: channel c sample k at bits [(c*8+k)*12 +: 12]
  input  wire logic [383:0]             sample_in,
  // Serializer side
  output logic [191:0]                  lane_data,
  output logic [7:0]                    lane_drive_en,
  output logic                          sync_hdr_crc12,
  output logic                          link_layer_bypass,
  output logic                          transport_bypass,
  output logic [1:0]                    channel_pair_power
);

  //////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic is_64b(input logic [3:0] fmt);
    is_64b = (fmt == 4'h8) || (fmt == 4'hC) || (fmt == 4'hE) || (fmt == 4'hF);
  endfunction

  // Four-lane formats; all others use eight lanes
  function automatic logic four_lane(input logic [3:0] fmt);
    four_lane = (fmt < 4'h9) && (fmt != lane_ctrl_pkg::FMT_0);
  endfunction

  // Short transport value: lane code in the upper nibbles, slot in the low one
  function automatic logic [11:0] st_val(input logic [2:0] lane, input logic [3:0] k);
    st_val = {4'hF - {1'b0, lane}, {1'b0, lane}, k};
  endfunction

  // Advance a PRBS register by one lane word; bit 0 is the newest bit
  function automatic logic [54:0] prbs_step(input logic [30:0] s, input logic [3:0] sel);
    logic [30:0] st;
    logic [23:0] out;
    logic        nb;
    st  = s;
    out = '0;
    for (int i = 0; i < 24; i++) begin
      case (sel)
        lane_ctrl_pkg::TST_PRBS7:  nb = st[5] ^ st[6];
        lane_ctrl_pkg::TST_PRBS9:  nb = st[4] ^ st[8];
        lane_ctrl_pkg::TST_PRBS15: nb = st[13] ^ st[14];
        lane_ctrl_pkg::TST_PRBS23: nb = st[17] ^ st[22];
        default:                   nb = st[27] ^ st[30];
      endcase
      st           = {st[29:0], nb};
      out[23 - i]  = nb;
    end
    prbs_step = {out, st};
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Registers

  logic [3:0]  link_format_select;
  logic        lane_group_select;
  logic        link_enable;
  logic [1:0]  channel_pair_enable;
  logic [3:0]  serializer_test_select;
  logic        aw_held;
  logic        w_held;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        ramp_run;
  logic [7:0]  ramp_oct;
  logic [2:0]  st_ptr;
  logic        clk_ph;
  logic [30:0] prbs_st [8];
  logic [54:0] prbs_nx [8];
  logic [3:0]  prev_test;
  logic [7:0]  next_drive;
  logic [191:0] next_data;
  logic        red_ok;
  logic        is_prbs;
  logic        do_write;

  assign red_ok   = four_lane(link_format_select);
  assign is_prbs  = (serializer_test_select >= lane_ctrl_pkg::TST_PRBS7) &&
                    (serializer_test_select <= lane_ctrl_pkg::TST_PRBS31);
  assign do_write = aw_held && w_held && !s_axi_bvalid;

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  //////////////////////////////////////////////////////////////////////////////
  // Write channel

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (do_write) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (do_write) begin
      w_held <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= lane_ctrl_pkg::RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      if (aw_addr[7:2] == lane_ctrl_pkg::OFS_CTRL[7:2] ||
          aw_addr[7:2] == lane_ctrl_pkg::OFS_TEST[7:2] ||
          aw_addr[7:2] == lane_ctrl_pkg::OFS_STATUS[7:2]) begin
        s_axi_bresp <= lane_ctrl_pkg::RESP_OKAY;
      end else begin
        s_axi_bresp <= lane_ctrl_pkg::RESP_SLVERR;
      end
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Control register; shutdown never touches it
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      link_format_select  <= lane_ctrl_pkg::RST_FMT;
      lane_group_select   <= 1'b0;
      link_enable         <= 1'b0;
      channel_pair_enable <= lane_ctrl_pkg::RST_CHEN;
    end else if (do_write && aw_addr[7:2] == lane_ctrl_pkg::OFS_CTRL[7:2] && w_strb[0]) begin
      link_format_select <= w_data[lane_ctrl_pkg::FMT_LSB +: lane_ctrl_pkg::FMT_W];
      lane_group_select  <= w_data[lane_ctrl_pkg::GRP_BIT];
      link_enable        <= w_data[lane_ctrl_pkg::LINK_BIT];
      // Both pairs off is refused; full power-down belongs to the shutdown pin
      if (w_data[lane_ctrl_pkg::CHEN_LSB +: 2] != 2'h0) begin
        channel_pair_enable <= w_data[lane_ctrl_pkg::CHEN_LSB +: 2];
      end
    end
  end

  // Test selector moves only while the link is down
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      serializer_test_select <= lane_ctrl_pkg::RST_TEST;
    end else if (do_write && aw_addr[7:2] == lane_ctrl_pkg::OFS_TEST[7:2] && w_strb[0] &&
                 !link_enable) begin
      serializer_test_select <= w_data[lane_ctrl_pkg::TEST_LSB +: lane_ctrl_pkg::TEST_W];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read channel

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= lane_ctrl_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= lane_ctrl_pkg::RESP_OKAY;
      s_axi_rdata  <= 32'h0000_0000;
      if (s_axi_araddr[7:2] == lane_ctrl_pkg::OFS_CTRL[7:2]) begin
        s_axi_rdata[lane_ctrl_pkg::FMT_LSB +: lane_ctrl_pkg::FMT_W] <= link_format_select;
        s_axi_rdata[lane_ctrl_pkg::GRP_BIT]      <= lane_group_select;
        s_axi_rdata[lane_ctrl_pkg::LINK_BIT]     <= link_enable;
        s_axi_rdata[lane_ctrl_pkg::CHEN_LSB +: 2] <= channel_pair_enable;
      end else if (s_axi_araddr[7:2] == lane_ctrl_pkg::OFS_TEST[7:2]) begin
        s_axi_rdata[lane_ctrl_pkg::TEST_LSB +: lane_ctrl_pkg::TEST_W] <= serializer_test_select;
      end else if (s_axi_araddr[7:2] == lane_ctrl_pkg::OFS_STATUS[7:2]) begin
        s_axi_rdata[lane_ctrl_pkg::ST_SHDN_BIT] <= full_shutdown_input;
        s_axi_rdata[lane_ctrl_pkg::ST_RAMP_BIT] <= ramp_run;
        s_axi_rdata[lane_ctrl_pkg::ST_RED_BIT]  <= red_ok;
        s_axi_rdata[lane_ctrl_pkg::ST_LANE_LSB +: 8] <= lane_drive_en;
      end else begin
        s_axi_rresp <= lane_ctrl_pkg::RESP_SLVERR;
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Pattern state

  // Ramp waits for alignment (8B/10B) or serializer init (64B/66B)
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ramp_run <= 1'b0;
      ramp_oct <= 8'h00;
    end else if (serializer_test_select != lane_ctrl_pkg::TST_RAMP || !link_enable ||
                 full_shutdown_input) begin
      ramp_run <= 1'b0;
      ramp_oct <= 8'h00;
    end else if (!ramp_run) begin
      ramp_run <= is_64b(link_format_select) ? serdes_ready : align_seq_done;
    end else begin
      ramp_oct <= ramp_oct + lane_ctrl_pkg::RAMP_STEP;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_ptr <= 3'h0;
      clk_ph <= 1'b0;
    end else begin
      st_ptr <= (serializer_test_select == lane_ctrl_pkg::TST_SHORT) ? st_ptr + 3'h1 : 3'h0;
      clk_ph <= (serializer_test_select == lane_ctrl_pkg::TST_CLOCK) ? !clk_ph : 1'b0;
    end
  end

  // One word ahead of every lane; the result is split, as a call cannot be sliced
  always_comb begin
    for (int l = 0; l < lane_ctrl_pkg::LANES; l++) begin
      prbs_nx[l] = prbs_step(prbs_st[l], serializer_test_select);
    end
  end

  // Reseeding on a mode change gives each lane its own known start
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      prev_test <= lane_ctrl_pkg::RST_TEST;
      for (int l = 0; l < lane_ctrl_pkg::LANES; l++) begin
        prbs_st[l] <= 31'h7FFF_FFFF;
      end
    end else begin
      prev_test <= serializer_test_select;
      for (int l = 0; l < lane_ctrl_pkg::LANES; l++) begin
        if (prev_test != serializer_test_select) begin
          prbs_st[l] <= 31'h7FFF_FFFF ^ 31'(2 * l);
        end else begin
          prbs_st[l] <= prbs_nx[l][30:0];
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Lane words and driver enables

  always_comb begin
    logic [11:0]  sa;
    logic [11:0]  sb;
    logic [63:0]  frame;
    logic [191:0] triple;
    logic [2:0]   ln;
    logic [2:0]   src;
    int           ch;
    sa        = '0;
    sb        = '0;
    frame     = '0;
    triple    = '0;
    ln        = '0;
    src       = '0;
    ch        = 0;
    next_data = '0;
    for (int l = 0; l < lane_ctrl_pkg::LANES; l++) begin
      ln  = 3'(l);
      // Four-lane formats mirror lanes 0-3 onto the alternate group
      src = (red_ok && l > 3) ? 3'(l - 4) : ln;
      if (link_format_select == lane_ctrl_pkg::FMT_15) begin
        ch = (src > 3'h3) ? 1 : 0;
        sa = sample_in[(ch * 8 + int'(src[1:0])) * 12 +: 12];
        sb = sample_in[(ch * 8 + int'(src[1:0]) + 4) * 12 +: 12];
      end else begin
        ch = int'(src[2:1]);
        sa = sample_in[(ch * 8 + int'(src[0])) * 12 +: 12];
        sb = sample_in[(ch * 8 + int'(src[0]) + 2) * 12 +: 12];
      end
      case (serializer_test_select)
        lane_ctrl_pkg::TST_PRBS7, lane_ctrl_pkg::TST_PRBS9, lane_ctrl_pkg::TST_PRBS15,
        lane_ctrl_pkg::TST_PRBS23, lane_ctrl_pkg::TST_PRBS31: begin
          next_data[l * 24 +: 24] = prbs_nx[l][54:31];
        end
        lane_ctrl_pkg::TST_CLOCK: begin
          next_data[l * 24 +: 24] = lane_ctrl_pkg::CLK_PAT48[(clk_ph ? 0 : 24) +: 24];
        end
        lane_ctrl_pkg::TST_RAMP: begin
          // Samples are ignored; octets feed the link layer directly
          if (ramp_run) begin
            next_data[l * 24 +: 24] = {ramp_oct, ramp_oct + 8'h01, ramp_oct + 8'h02};
          end
        end
        lane_ctrl_pkg::TST_SHORT: begin
          if (link_format_select == lane_ctrl_pkg::FMT_0) begin
            // 64-bit frame in 24-bit words: three frames fill eight words
            frame  = {st_val(src, 4'h1), st_val(src, 4'h2), st_val(src, 4'h3),
                      st_val(src, 4'h4), st_val(src, 4'h5), lane_ctrl_pkg::SHORT_TAIL};
            triple = {frame, frame, frame};
            next_data[l * 24 +: 24] = triple[168 - 24 * int'(st_ptr) +: 24];
          end else begin
            next_data[l * 24 +: 24] = {st_val(src, 4'h1), st_val(src, 4'h2)};
          end
        end
        default: begin
          next_data[l * 24 +: 24] = {sa, sb};
        end
      endcase
    end
  end

  always_comb begin
    next_drive = 8'h00;
    if (!full_shutdown_input && link_enable) begin
      if (!red_ok) begin
        next_drive = 8'hFF;
      end else if (lane_group_select) begin
        next_drive = 8'hF0;
      end else begin
        next_drive = 8'h0F;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      lane_data          <= '0;
      lane_drive_en      <= 8'h00;
      link_layer_bypass  <= 1'b0;
      transport_bypass   <= 1'b0;
      channel_pair_power <= 2'h0;
    end else begin
      lane_data          <= next_data;
      lane_drive_en      <= next_drive;
      link_layer_bypass  <= is_prbs || serializer_test_select == lane_ctrl_pkg::TST_CLOCK;
      transport_bypass   <= is_prbs || serializer_test_select == lane_ctrl_pkg::TST_CLOCK ||
                            serializer_test_select == lane_ctrl_pkg::TST_RAMP;
      channel_pair_power <= full_shutdown_input ? 2'h0 : channel_pair_enable;
    end
  end

  // CRC-3 is never offered
  assign sync_hdr_crc12 = 1'b1;

endmodule // serdes_test_pattern_lane_control

// ---- tb/lane_ctrl_monitor.sv ----
`timescale 1ns/10ps
module lane_ctrl_monitor (
  // Clock and reset
  input wire logic         clk,
  input wire logic         rst_b,
  // Watched ports
  input wire logic         full_shutdown_input,
  input wire logic [191:0] lane_data,
  input wire logic [7:0]   lane_drive_en,
  input wire logic         sync_hdr_crc12,
  input wire logic         link_layer_bypass,
  input wire logic         transport_bypass,
  input wire logic [1:0]   channel_pair_power
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);

  wire ramp_on = transport_bypass && !link_layer_bypass;

  ////////////////////////////////////////////////////////////////////////////////
  chk_crc_only: assert property (sync_hdr_crc12)
    else $error("sync header check is not the twelve-bit kind");
  chk_shdn_off: assert property (full_shutdown_input |=>
    lane_drive_en == 8'h00 && channel_pair_power == 2'h0)
    else $error("drivers still on during shutdown");
  chk_one_group: assert property (lane_drive_en inside {8'h00, 8'h0F, 8'hF0, 8'hFF})
    else $error("lane enables mix both groups");
  chk_alt_copy: assert property (
    (lane_drive_en inside {8'h0F, 8'hF0}) && !link_layer_bypass |->
    lane_data[191:96] == lane_data[95:0])
    else $error("alternate group differs from default group");
  // Three quiet cycles: the register still shows its reset zero one edge after release
  chk_pair_live: assert property (!full_shutdown_input [*3] |-> channel_pair_power != 2'h0)
    else $error("all channel pairs powered down");
  chk_prbs_raw: assert property (link_layer_bypass |-> transport_bypass)
    else $error("link layer bypassed without transport bypass");
  chk_ramp_same: assert property (ramp_on |-> lane_data == {8{lane_data[23:0]}})
    else $error("ramp lanes differ");
  chk_ramp_count: assert property (ramp_on && lane_data[23:0] != 24'h000000 |->
    lane_data[15:8] == lane_data[23:16] + 8'h01 && lane_data[7:0] == lane_data[15:8] + 8'h01)
    else $error("ramp octets not consecutive");
  chk_clk_pat: assert property (
    lane_data[23:0] == 24'hFF00FF ##1 lane_data[23:0] == 24'h00FF00 |=>
    !link_layer_bypass || lane_data[23:0] == 24'hFF00FF)
    else $error("clock pattern does not repeat");

  cov_ramp: cover property (ramp_on && lane_data[23:0] != 24'h000000);
  cov_alt: cover property (lane_drive_en == 8'hF0);
  cov_shdn: cover property (full_shutdown_input ##1 !full_shutdown_input);
endmodule // lane_ctrl_monitor

// ---- tb/jesd_rx_model.sv ----
`timescale 1ns/10ps
module jesd_rx_model (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_b,
  // Link side
  input  wire logic [7:0] lane_drive_en,
  input  wire logic [7:0] ready_delay,
  output logic            serdes_ready,
  output logic            align_seq_done
);
  logic [8:0] cnt;

  // Relink from scratch whenever drivers go quiet: stale pipeline words are never trusted
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) cnt <= 9'h000;
    else if (lane_drive_en == 8'h00) cnt <= 9'h000;
    else if (cnt != 9'h1FF) cnt <= cnt + 9'h001;
  end
  assign serdes_ready   = cnt > {1'b0, ready_delay};
  assign align_seq_done = cnt > {1'b0, ready_delay} + 9'h004;
endmodule // jesd_rx_model

// ---- tb/tb.sv ----
`timescale 1ns/10ps
module tb;
  localparam logic [1:0] OK  = lane_ctrl_pkg::RESP_OKAY;
  localparam logic [1:0] ERR = lane_ctrl_pkg::RESP_SLVERR;
  localparam logic [7:0] CTL = lane_ctrl_pkg::OFS_CTRL;
  localparam logic [7:0] TST = lane_ctrl_pkg::OFS_TEST;
  localparam logic [7:0] STA = lane_ctrl_pkg::OFS_STATUS;
  localparam int TAP_A[5] = '{6, 5, 14, 18, 28};
  localparam int TAP_B[5] = '{7, 9, 15, 23, 31};
  logic         clk = 1'b0, rst_b = 1'b0, shdn = 1'b0;
  logic [7:0]   awaddr = 8'h00, araddr = 8'h00, drv_en, rdly = 8'h02;
  logic [31:0]  wdata = 32'h0, rdata;
  logic         awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic         awready, wready, bvalid, arready, rvalid, srdy, adone, crc12, llb, tpb;
  logic [1:0]   bresp, rresp, pair_pwr;
  logic [383:0] samples;
  logic [191:0] lanes;
  int           failures = 0, total_checks = 0, cycles = 0;

  always #50 clk = ~clk;

  serdes_test_pattern_lane_control uut (
    .clk(clk), .rst_b(rst_b), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .full_shutdown_input(shdn), .serdes_ready(srdy), .align_seq_done(adone),
    .sample_in(samples), .lane_data(lanes), .lane_drive_en(drv_en), .sync_hdr_crc12(crc12),
    .link_layer_bypass(llb), .transport_bypass(tpb), .channel_pair_power(pair_pwr));

  jesd_rx_model rx (.clk(clk), .rst_b(rst_b), .lane_drive_en(drv_en), .ready_delay(rdly),
    .serdes_ready(srdy), .align_seq_done(adone));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t ns: seen 0x%h expected 0x%h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    if (failures == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Address and data are offered together; each is dropped at the edge it is taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge clk);
      if (awvalid && awready) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge clk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    check(32'(bresp), 32'(er));
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk); while (rvalid !== 1'b1);
    rready <= 1'b0;
    d = rdata;
    check(32'(rresp), 32'(er));
    @(posedge clk);
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] v;
    rd(a, OK, v);
    check(v, e);
  endtask

  function automatic logic [11:0] smp(input int c, input int k);
    return 12'(12'hA00 + c * 16 + k);
  endfunction

  function automatic logic [31:0] cw(input logic [3:0] f, input logic g, input logic lk,
                                     input logic [1:0] p);
    return {24'h0, p, lk, g, f};
  endfunction

  task automatic chk_map(input logic f15);
    logic [23:0] e;
    for (int l = 0; l < 8; l++) begin
      if (f15) e = {smp(l / 4, l % 4), smp(l / 4, l % 4 + 4)};
      else e = {smp(l / 2, l % 2), smp(l / 2, l % 2 + 2)};
      check(32'(lanes[l*24 +: 24]), 32'(e));
    end
  endtask

  // Test select may only move while the link is off
  task automatic set_test(input logic [3:0] f, input logic [3:0] t);
    wr(CTL, cw(f, 1'b0, 1'b0, 2'h3), OK);
    wr(TST, {28'h0, t}, OK);
    wr(CTL, cw(f, 1'b0, 1'b1, 2'h3), OK);
    tick(3);
  endtask

  // Eight successive words of one lane, oldest in the top bits
  task automatic grab(input int l, output logic [191:0] s);
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      s = {s[167:0], lanes[l*24 +: 24]};
    end
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      summarize();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [191:0] s;
    logic [63:0]  fr;
    logic [383:0] dbl;
    logic [31:0]  v;
    int           err;
    logic         hit;
    for (int i = 0; i < 32; i++) samples[i*12 +: 12] <= smp(i / 8, i % 8);
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    rc(CTL, 32'h0000_00CE);
    rc(TST, 32'h0);
    rc(STA, 32'h0);
    check(32'(crc12), 32'h1);
    rd(8'h0C, ERR, v);
    check(v, 32'h0);
    wr(8'h0C, 32'h1, ERR);
    wr(CTL, cw(4'hE, 1'b0, 1'b1, 2'h3), OK);
    wr(TST, 32'(lane_ctrl_pkg::TST_CLOCK), OK);
    rc(TST, 32'h0);
    tick(2);
    chk_map(1'b0);
    check(32'({drv_en, llb, tpb}), 32'h3FC);
    wr(CTL, cw(4'hF, 1'b0, 1'b1, 2'h3), OK);
    tick(2);
    chk_map(1'b1);
    wr(CTL, cw(4'h8, 1'b0, 1'b1, 2'h0), OK);
    tick(2);
    check(32'({drv_en, pair_pwr}), 32'h03F);
    rc(STA, 32'h0F04);
    wr(CTL, cw(4'h8, 1'b1, 1'b1, 2'h1), OK);
    tick(2);
    check(32'({drv_en, pair_pwr}), 32'h3C1);
    shdn <= 1'b1;
    tick(2);
    check(32'({drv_en, pair_pwr}), 32'h0);
    rc(CTL, cw(4'h8, 1'b1, 1'b1, 2'h1));
    rc(STA, 32'h0005);
    shdn <= 1'b0;
    tick(2);
    check(32'({drv_en, pair_pwr}), 32'h3C1);
    for (int m = 0; m < 5; m++) begin
      set_test(4'hE, 4'(m + 1));
      check(32'({drv_en, llb, tpb}), 32'h3FF);
      check(32'(lanes[23:0] == lanes[47:24]), 32'h0);
      grab(0, s);
      err = 0;
      for (int n = 31; n < 192; n++)
        if (s[191-n] !== (s[191-n+TAP_A[m]] ^ s[191-n+TAP_B[m]])) err++;
      check(32'(err), 32'h0);
    end
    set_test(4'hE, lane_ctrl_pkg::TST_CLOCK);
    grab(3, s);
    check(32'(s[191:144] == 48'hFF00FF00FF00 || s[191:144] == 48'h00FF00FF00FF), 32'h1);
    rdly <= 8'd20;
    set_test(4'hE, lane_ctrl_pkg::TST_RAMP);
    check(32'(lanes[23:0]), 32'h0);
    check(32'({llb, tpb}), 32'h1);
    while (srdy !== 1'b1) @(posedge clk);
    tick(3);
    grab(5, s);
    check(32'({s[167:160] - s[191:184], s[159:152] - s[183:176], s[151:144] - s[175:168]}),
          32'h030303);
    rc(STA, 32'hFF02);
    set_test(4'h0, lane_ctrl_pkg::TST_SHORT);
    for (int l = 0; l < 8; l += 7) begin
      fr = 64'h0;
      for (int k = 1; k < 6; k++) fr = {fr[51:0], 4'(15 - l), 4'(l), 4'(k)};
      fr = {fr[59:0], lane_ctrl_pkg::SHORT_TAIL};
      dbl = {6{fr}};
      grab(l, s);
      hit = 1'b0;
      for (int r = 0; r < 8; r++)
        if (s === dbl[383 - 24 * r -: 192]) hit = 1'b1;
      check(32'(hit), 32'h1);
    end
    set_test(4'hE, lane_ctrl_pkg::TST_OFF);
    chk_map(1'b0);
    check(32'({llb, tpb}), 32'h0);
    summarize();
  end
endmodule // tb

bind serdes_test_pattern_lane_control lane_ctrl_monitor mon (
  .clk(clk), .rst_b(rst_b), .full_shutdown_input(full_shutdown_input), .lane_data(lane_data),
  .lane_drive_en(lane_drive_en), .sync_hdr_crc12(sync_hdr_crc12),
  .link_layer_bypass(link_layer_bypass), .transport_bypass(transport_bypass),
  .channel_pair_power(channel_pair_power));
